/* fwc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fwc_consts.svh"

module fwc_top
#(
	parameter int REPEATS = `FWC_TEN_REPEATS
)
(
	// clock and reset
	input  wire logic                   core_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   clk_en_i,
	// host register port
	input  wire fwc_pkg::fwc_host_req_t host_req_i,
	output var  logic [7:0]             host_rdata_o,
	// transmit c3 bit stream
	input  wire logic                   tx_slot_i,
	output var  logic                   tx_c3_o,
	// receive c3 bit stream
	input  wire logic                   rx_slot_i,
	input  wire logic                   rx_c3_i
);
	import fwc_pkg::*;

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		reg_hit = (addr == ofs);
	endfunction

	fwc_tx_state_t state;
	logic          mode;
	logic [5:0]    tx_code;
	logic [3:0]    bit_cnt;
	logic [3:0]    rep_cnt;
	logic [15:0]   tx_word;

	logic [15:0]   rx_shift;
	logic [15:0]   next_rx_shift;
	logic          match;
	logic          all_ones;
	logic [5:0]    match_code;
	logic          idle_flag;
	logic          new_flag;
	logic [5:0]    rx_code;

	logic          tx_wr;
	logic          rx_rd;
	logic          word_end;
	logic          last_word;

	assign tx_wr     = host_req_i.wr && reg_hit(host_req_i.addr, `FWC_TX_OFS);
	assign rx_rd     = host_req_i.rd && reg_hit(host_req_i.addr, `FWC_RX_OFS);
	// framing zeros and trailing ones added here, code sits msb-first
	assign tx_word   = {1'b0, tx_code, 1'b0, `FWC_ONES_FIELD};
	assign word_end  = tx_slot_i && (bit_cnt == 4'(`FWC_WORD_BITS - 1));
	assign last_word = (rep_cnt == 4'(REPEATS - 1));

	// transmit control and sequencing
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state   <= FWC_ST_IDLE;
			mode    <= 1'b0;
			tx_code <= 6'h00;
			bit_cnt <= 4'h0;
			rep_cnt <= 4'h0;
		end
		else if (clk_en_i)
		begin
			case (state)
				FWC_ST_IDLE:
				begin
					if (tx_wr)
					begin
						mode    <= host_req_i.wdata[`FWC_MODE_BIT];
						tx_code <= host_req_i.wdata[5:0];
						bit_cnt <= 4'h0;
						rep_cnt <= 4'h0;
						if (host_req_i.wdata[`FWC_GO_BIT])
						begin
							state <= FWC_ST_SEND;
						end
					end
				end
				FWC_ST_SEND:
				begin
					// code is locked while busy; only a stop write in continuous mode is honoured
					if (tx_wr && mode && !host_req_i.wdata[`FWC_MODE_BIT])
					begin
						mode  <= 1'b0;
						state <= FWC_ST_IDLE;
					end
					else if (tx_slot_i)
					begin
						bit_cnt <= bit_cnt + 4'h1;
						if (word_end)
						begin
							if (!mode && last_word)
							begin
								state <= FWC_ST_IDLE;
							end
							else if (!mode)
							begin
								rep_cnt <= rep_cnt + 4'h1;
							end
						end
					end
				end
				default:
				begin
					state <= FWC_ST_IDLE;
				end
			endcase
		end
	end

	// line output; idle channel carries ones
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			tx_c3_o <= 1'b1;
		end
		else if (clk_en_i && tx_slot_i)
		begin
			if (state == FWC_ST_SEND)
			begin
				tx_c3_o <= tx_word[4'(`FWC_WORD_BITS - 1) - bit_cnt];
			end
			else
			begin
				tx_c3_o <= 1'b1;
			end
		end
	end

	assign next_rx_shift = {rx_shift[14:0], rx_c3_i};
	assign match         = rx_slot_i && !next_rx_shift[15] && !next_rx_shift[8]
		&& (next_rx_shift[7:0] == `FWC_ONES_FIELD);
	assign all_ones      = rx_slot_i && (&next_rx_shift);
	assign match_code    = next_rx_shift[14:9];

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rx_shift <= 16'hFFFF;
		end
		else if (clk_en_i && rx_slot_i)
		begin
			rx_shift <= next_rx_shift;
		end
	end

	// receive status; set beats the read clear
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			idle_flag <= `FWC_IDLE_RST;
			new_flag  <= 1'b0;
			rx_code   <= 6'h00;
		end
		else if (clk_en_i)
		begin
			if (match)
			begin
				idle_flag <= 1'b0;
				new_flag  <= 1'b1;
				rx_code   <= match_code;
			end
			else
			begin
				if (all_ones)
				begin
					idle_flag <= 1'b1;
				end
				if (rx_rd)
				begin
					new_flag <= 1'b0;
				end
			end
		end
	end

	// registered read data, zero for unmapped addresses
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			host_rdata_o <= 8'h00;
		end
		else if (clk_en_i && host_req_i.rd)
		begin
			if (reg_hit(host_req_i.addr, `FWC_TX_OFS))
			begin
				host_rdata_o <= {(state == FWC_ST_SEND), mode, tx_code};
			end
			else if (rx_rd)
			begin
				host_rdata_o <= {idle_flag, new_flag, rx_code};
			end
			else
			begin
				host_rdata_o <= 8'h00;
			end
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	property p_go_start;
		clk_en_i && tx_wr && host_req_i.wdata[7] && state == FWC_ST_IDLE |=> state == FWC_ST_SEND;
	endproperty
	a_go_start: assert property (p_go_start) else $error("go write did not start");

	property p_ten_stop;
		clk_en_i && state == FWC_ST_SEND && !mode && word_end && last_word && !tx_wr
			|=> state == FWC_ST_IDLE;
	endproperty
	a_ten_stop: assert property (p_ten_stop) else $error("tenth word did not end");

	property p_early_keep;
		clk_en_i && state == FWC_ST_SEND && word_end && (mode || !last_word) && !tx_wr
			|=> state == FWC_ST_SEND;
	endproperty
	a_early_keep: assert property (p_early_keep) else $error("sending ended early");

	property p_stop_write;
		clk_en_i && state == FWC_ST_SEND && mode && tx_wr && !host_req_i.wdata[6]
			|=> state == FWC_ST_IDLE && !mode;
	endproperty
	a_stop_write: assert property (p_stop_write) else $error("stop write ignored");

	property p_code_kept;
		state == FWC_ST_SEND ##1 state == FWC_ST_IDLE |-> $stable(tx_code);
	endproperty
	a_code_kept: assert property (p_code_kept) else $error("code changed at end");

	property p_frame_zero;
		clk_en_i && tx_slot_i && state == FWC_ST_SEND && (bit_cnt == 4'h0 || bit_cnt == 4'h7)
			|=> !tx_c3_o;
	endproperty
	a_frame_zero: assert property (p_frame_zero) else $error("framing zero missing");

	property p_idle_clear;
		clk_en_i && match |=> !idle_flag && new_flag ##1 !idle_flag || rx_slot_i;
	endproperty
	a_idle_clear: assert property (p_idle_clear) else $error("idle not cleared");

	property p_read_keeps_idle;
		clk_en_i && rx_rd && !match && !all_ones |=> $stable(idle_flag) && !new_flag;
	endproperty
	a_read_keeps_idle: assert property (p_read_keeps_idle) else $error("read hit idle");

	property p_rx_code;
		clk_en_i && match |=> rx_code == $past(match_code);
	endproperty
	a_rx_code: assert property (p_rx_code) else $error("rx code wrong");

	property p_no_false_new;
		clk_en_i && !match && !new_flag |=> !new_flag;
	endproperty
	a_no_false_new: assert property (p_no_false_new) else $error("new without match");

endmodule

`default_nettype wire

/* fwc_consts.svh */
`ifndef FWC_CONSTS_SVH
`define FWC_CONSTS_SVH

`define FWC_TX_OFS       8'h1C
`define FWC_RX_OFS       8'h1D
`define FWC_GO_BIT       7
`define FWC_MODE_BIT     6
`define FWC_IDLE_BIT     7
`define FWC_NEW_BIT      6
`define FWC_WORD_BITS    16
`define FWC_TEN_REPEATS  10
`define FWC_ONES_FIELD   8'hFF
`define FWC_IDLE_RST     1'b1

`endif

/* fwc_pkg.sv */
package fwc_pkg;

	typedef enum logic [1:0]
	{
		FWC_ST_IDLE = 2'b01,
		FWC_ST_SEND = 2'b10
	} fwc_tx_state_t;

	// one host access per cycle; wr and rd are one-cycle strobes
	typedef struct packed
	{
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fwc_host_req_t;

endpackage

/* fwc_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module fwc_far_end
(
	// clock
	input  wire logic       core_clk_i,
	// line to and from the block
	input  wire logic       tx_c3_i,
	output var  logic       slot_o,
	output var  logic       rx_c3_o,
	// words seen on the line
	output var  logic [7:0] words_o,
	output var  logic [5:0] code_o
);
	logic [15:0] sh;

	initial
	begin
		slot_o = 1'b0;
		rx_c3_o = 1'b1;
		words_o = 8'h00;
		code_o = 6'h00;
		sh = 16'hFFFF;
	end

	// remote end loops our bits back; a slot every other cycle
	always @(negedge core_clk_i)
	begin
		slot_o <= !slot_o;
		if (!slot_o)
		begin
			sh <= {sh[14:0], tx_c3_i};
			rx_c3_o <= tx_c3_i;
			if (sh[14] == 1'b0 && sh[7] == 1'b0 && {sh[6:0], tx_c3_i} == 8'hFF)
			begin
				words_o <= words_o + 8'h01;
				code_o <= sh[13:8];
			end
		end
	end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fwc_pkg::*;
	logic          core_clk_i = 1'b0;
	logic          resetn_i = 1'b0;
	logic          clk_en = 1'b1;
	fwc_host_req_t req;
	logic [7:0]    rdata;
	logic [7:0]    words;
	logic [7:0]    w0;
	logic [5:0]    code;
	logic          tx_c3;
	logic          slot;
	logic          rx_c3;
	int            fails = 0;
	int            n_tests = 0;
	// code, then status expected at first read
	logic [13:0]   rows [4] = '{{6'h00, 8'hC0}, {6'h3F, 8'hFF}, {6'h15, 8'hD5}, {6'h2A, 8'hEA}};

	always #5 core_clk_i = !core_clk_i;

	fwc_top #(.REPEATS(2)) fwc_top_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.clk_en_i(clk_en), .host_req_i(req), .host_rdata_o(rdata), .tx_slot_i(slot),
		.tx_c3_o(tx_c3), .rx_slot_i(slot), .rx_c3_i(rx_c3));
	fwc_far_end fwc_far_end_i (.core_clk_i(core_clk_i), .tx_c3_i(tx_c3), .slot_o(slot),
		.rx_c3_o(rx_c3), .words_o(words), .code_o(code));

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_i);
		req = '{w, !w, a, d};
		@(negedge core_clk_i);
		req = '0;
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		#100us;
		fails++;
		summarize();
	end

	initial
	begin
		req = '0;
		repeat (16) @(negedge core_clk_i);
		resetn_i = 1'b1;
		acc(1'b0, 8'h1D, 8'h00);
		chk(rdata, 8'h80);
		acc(1'b0, 8'h1C, 8'h00);
		chk(rdata, 8'h00);
		acc(1'b0, 8'h00, 8'h00);
		chk(rdata, 8'h00);
		$display("test reset done");
		foreach (rows[i])
		begin
			w0 = words;
			acc(1'b1, 8'h1C, {2'b10, rows[i][13:8]});
			acc(1'b0, 8'h1C, 8'h00);
			chk(rdata, {2'b10, rows[i][13:8]});
			for (int k = 0; k < 200; k++)
				if (rdata[7] === 1'b1)
					acc(1'b0, 8'h1C, 8'h00);
			chk(rdata, {2'b00, rows[i][13:8]});
			repeat (40) @(negedge core_clk_i);
			chk(words - w0, 8'h02);
			chk({2'b00, code}, {2'b00, rows[i][13:8]});
			acc(1'b0, 8'h1D, 8'h00);
			chk(rdata, rows[i][7:0]);
			acc(1'b0, 8'h1D, 8'h00);
			chk(rdata, rows[i][7:0] & 8'hBF);
			$display("test row %0d done", i);
		end
		acc(1'b1, 8'h1C, 8'hC5);
		repeat (120) @(negedge core_clk_i);
		acc(1'b0, 8'h1D, 8'h00);
		chk(rdata, 8'h45);
		// a second start while running is ignored
		acc(1'b1, 8'h1C, 8'hEA);
		acc(1'b0, 8'h1C, 8'h00);
		chk(rdata, 8'hC5);
		repeat (60) @(negedge core_clk_i);
		acc(1'b0, 8'h1D, 8'h00);
		chk(rdata, 8'h45);
		acc(1'b1, 8'h1C, 8'h3F);
		acc(1'b0, 8'h1C, 8'h00);
		chk({7'h00, rdata[7]}, 8'h00);
		repeat (40) @(negedge core_clk_i);
		w0 = words;
		repeat (80) @(negedge core_clk_i);
		chk(words - w0, 8'h00);
		acc(1'b0, 8'h1D, 8'h00);
		acc(1'b0, 8'h1D, 8'h00);
		chk(rdata & 8'hC0, 8'h80);
		$display("test continuous done");
		// frozen cycles must swallow a start write
		clk_en = 1'b0;
		acc(1'b1, 8'h1C, 8'h80);
		clk_en = 1'b1;
		acc(1'b0, 8'h1C, 8'h00);
		chk(rdata, 8'h05);
		w0 = words;
		acc(1'b1, 8'h1C, 8'h2A);
		acc(1'b0, 8'h1C, 8'h00);
		chk(rdata, 8'h2A);
		repeat (40) @(negedge core_clk_i);
		chk(words - w0, 8'h00);
		$display("test enable done");
		summarize();
	end
endmodule
`default_nettype wire
